/* logic/lp_device.sv */
// Purpose: register bank of a single-cell protector, reached over the link
// Assumes: protection inputs are already qualified levels, synchronous to aclk
// Notes: every request gets rsp_valid one cycle later
//
// Decided for this implementation: the AXI4-Lite register port.
module lp_device
   import lp_pkg::*;
#(
   parameter logic [7:0] FAMILY_CODE = 8'h5a,  // arbitrary value
   parameter logic [47:0] SERIAL = 48'h0000_0000_0001,  // arbitrary value
   parameter logic [7:0] ID_CRC = 8'h00,  // arbitrary value
   parameter int COPY_CYCLES = LP_COPY_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link
   lp_link_if.device link,
   // cell conditions
   input wire logic cell_over_voltage,
   input wire logic cell_under_voltage,
   input wire logic pack_over_current,
   input wire logic die_over_temp,
   input wire logic charger_present,
   input wire logic power_switch_pin_n,
   // gate drive and mode
   output logic charge_gate,
   output logic discharge_gate,
   output logic active_mode
);
   import lp_pkg::*;

   typedef enum logic [1:0] {
      LP_MODE_ACTIVE = 2'b01,
      LP_MODE_SLEEP = 2'b10
   } lp_mode_t;

   lp_mode_t mode;
   logic high_cell_flag, low_cell_flag, excess_current_flag;
   logic charge_allow, discharge_allow;
   logic [2:0] boot_bits;
   logic copy_in_progress, freeze_arm;
   logic [1:0] block_frozen;
   logic copy_blk;
   logic [15:0] copy_cnt;
   logic switch_pin_latch, heat_flag;
   logic [7:0] shadow [0:7];
   logic [7:0] nvm [0:7];
   logic [63:0] identity;
   logic wr, is_nvm, blk, wake, nvm_wr_ok;
   logic [7:0] wd;

   assign identity = {ID_CRC, SERIAL, FAMILY_CODE};
   assign wd = link.req_data;
   assign wr = link.req_valid && (link.req_cmd == LP_CMD_WRITE);
   assign is_nvm = (link.req_addr[7:2] == LP_BLK0_WORD) || (link.req_addr[7:2] == LP_BLK1_WORD);
   assign blk = link.req_addr[4];
   assign wake = (mode == LP_MODE_SLEEP) && (!power_switch_pin_n || charger_present);
   assign nvm_wr_ok = wr && is_nvm && !copy_in_progress && !block_frozen[blk]
                      && (mode == LP_MODE_ACTIVE);
   assign active_mode = (mode == LP_MODE_ACTIVE);

   // ***************************************************
   // operating mode
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode <= LP_MODE_ACTIVE;
      end else begin
         unique case (mode)
            LP_MODE_ACTIVE: begin
               if (cell_under_voltage) begin
                  mode <= LP_MODE_SLEEP;
               end
            end
            LP_MODE_SLEEP: begin
               if (wake) begin
                  mode <= LP_MODE_ACTIVE;
               end
            end
         endcase
      end
   end

   // ***************************************************
   // protection flags and allows
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_cell_flag <= LP_HIGH_CELL_RST;
         low_cell_flag <= LP_LOW_CELL_RST;
         excess_current_flag <= LP_EXCESS_RST;
         charge_allow <= LP_ALLOW_RST;
         discharge_allow <= LP_ALLOW_RST;
      end else begin
         // event wins over a clearing write
         if (cell_over_voltage) begin
            high_cell_flag <= 1'b1;
         end else if (wr && link.req_addr == LP_REG_GUARD) begin
            high_cell_flag <= wd[LP_BIT_HIGH_CELL];
         end
         if (cell_under_voltage) begin
            low_cell_flag <= 1'b1;
         end else if (wr && link.req_addr == LP_REG_GUARD) begin
            low_cell_flag <= wd[LP_BIT_LOW_CELL];
         end
         if (pack_over_current) begin
            excess_current_flag <= 1'b1;
         end else if (wr && link.req_addr == LP_REG_GUARD) begin
            excess_current_flag <= wd[LP_BIT_EXCESS];
         end
         if (wake) begin
            charge_allow <= 1'b1;
            discharge_allow <= 1'b1;
         end else if (wr && link.req_addr == LP_REG_GUARD) begin
            charge_allow <= wd[LP_BIT_CHARGE_ALLOW];
            discharge_allow <= wd[LP_BIT_DISCHARGE_ALLOW];
         end
      end
   end

   // ***************************************************
   // gate drive
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         charge_gate <= 1'b0;
         discharge_gate <= 1'b0;
      end else begin
         charge_gate <= active_mode && charge_allow && !heat_flag && !die_over_temp
                        && !cell_over_voltage && !cell_under_voltage
                        && !pack_over_current;
         discharge_gate <= active_mode && discharge_allow && !heat_flag && !die_over_temp
                           && !cell_under_voltage && !pack_over_current;
      end
   end

   // ***************************************************
   // switch pin and heat
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switch_pin_latch <= LP_PIN_LATCH_RST;
         heat_flag <= LP_HEAT_RST;
      end else begin
         if (!power_switch_pin_n) begin
            switch_pin_latch <= 1'b0;
         end else if (wr && link.req_addr == LP_REG_SWITCH) begin
            switch_pin_latch <= wd[LP_BIT_PIN_LATCH];
         end
         if (die_over_temp) begin
            heat_flag <= 1'b1;
         end else if (wr && link.req_addr == LP_REG_SWITCH) begin
            heat_flag <= wd[LP_BIT_HEAT];
         end
      end
   end

   // ***************************************************
   // eeprom copy, recall and freeze
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         copy_in_progress <= 1'b0;
         copy_cnt <= '0;
         copy_blk <= 1'b0;
         freeze_arm <= LP_FREEZE_RST;
         block_frozen <= 2'b00;
      end else begin
         if (copy_in_progress) begin
            if (copy_cnt == '0) begin
               copy_in_progress <= 1'b0;
            end else begin
               copy_cnt <= copy_cnt - 16'h0001;
            end
         end else if (link.req_valid && link.req_cmd == LP_CMD_COPY && is_nvm && active_mode
                      && !block_frozen[blk]) begin
            copy_in_progress <= 1'b1;
            copy_cnt <= 16'(COPY_CYCLES - 1);
            copy_blk <= blk;
         end
         if (link.req_valid && link.req_cmd == LP_CMD_LOCK && is_nvm && freeze_arm) begin
            block_frozen[blk] <= 1'b1;
            freeze_arm <= 1'b0;
         end else if (wr && link.req_addr == LP_REG_NVM) begin
            freeze_arm <= wd[LP_BIT_FREEZE];
         end
      end
   end

   // shadow ram and nvm cells, one generate lane per byte
   for (genvar i = 0; i < 8; i++) begin : g_byte
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            shadow[i] <= LP_NVM_FACTORY;
            nvm[i] <= LP_NVM_FACTORY;
         end else begin
            if (nvm_wr_ok && {blk, link.req_addr[1:0]} == 3'(i)) begin
               shadow[i] <= wd;
            end else if (link.req_valid && link.req_cmd == LP_CMD_RECALL && is_nvm
                         && blk == 1'(i / 4)) begin
               shadow[i] <= nvm[i];
            end
            if (copy_in_progress && copy_cnt == '0 && copy_blk == 1'(i / 4)) begin
               nvm[i] <= shadow[i];
            end
         end
      end
   end

   // ***************************************************
   // status byte defaults
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_bits <= LP_NVM_FACTORY[LP_BIT_BOOT_HI:LP_BIT_BOOT_LO];
      end else if (link.req_valid && link.req_cmd == LP_CMD_RECALL && is_nvm && blk) begin
         boot_bits <= nvm[LP_BOOT_DEFAULT_IDX][LP_BIT_BOOT_HI:LP_BIT_BOOT_LO];
      end
   end

   // ***************************************************
   // link answers
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link.rsp_valid <= 1'b0;
         link.rsp_data <= '0;
      end else begin
         link.rsp_valid <= link.req_valid;
         link.rsp_data <= '0;
         if (link.req_cmd == LP_CMD_ID_READ) begin
            // wrong opcode: bus stays idle high; no crc check here
            if (link.req_data == (boot_bits[1] ? LP_OP_ID_B : LP_OP_ID_A)) begin
               link.rsp_data <= identity[{link.req_addr[2:0], 3'b000} +: 8];
            end else begin
               link.rsp_data <= LP_READ_IDLE;
            end
         end else if (link.req_cmd != LP_CMD_READ) begin
            // write, copy, recall and lock answer zero
            link.rsp_data <= '0;
         end else if (is_nvm) begin
            link.rsp_data <= shadow[{blk, link.req_addr[1:0]}];
         end else begin
            unique case (link.req_addr)
               LP_REG_GUARD: begin
                  link.rsp_data <= {high_cell_flag, low_cell_flag, 1'b0, excess_current_flag,
                                    charge_gate, discharge_gate, charge_allow,
                                    discharge_allow};
               end
               LP_REG_BOOT: link.rsp_data <= {2'b00, boot_bits, 3'b000};
               LP_REG_NVM: begin
                  link.rsp_data <= {copy_in_progress, freeze_arm, 4'h0, block_frozen};
               end
               LP_REG_SWITCH: link.rsp_data <= {switch_pin_latch, 6'h00, heat_flag};
               default: link.rsp_data <= '0;
            endcase
         end
      end
   end

endmodule // lp_device

/* logic/lp_pkg.sv */
// Purpose: shared constants and types of the cell protector register bank and its host
// Assumes: one 200 MHz clock, byte-wide register space
// Notes: offsets, bit positions, reset values and cycle counts live here; read-back bit layouts and some resets are hardcoded in the modules
package lp_pkg;

   // ***************************************************
   // device register map
   // ***************************************************
   localparam logic [7:0] LP_REG_GUARD = 8'h00;
   localparam logic [7:0] LP_REG_BOOT = 8'h01;
   localparam logic [7:0] LP_REG_NVM = 8'h07;
   localparam logic [7:0] LP_REG_SWITCH = 8'h08;
   localparam logic [5:0] LP_BLK0_WORD = 6'h08;
   localparam logic [5:0] LP_BLK1_WORD = 6'h0c;
   localparam logic [2:0] LP_BOOT_DEFAULT_IDX = 3'h5;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int LP_BIT_HIGH_CELL = 7;
   localparam int LP_BIT_LOW_CELL = 6;
   localparam int LP_BIT_EXCESS = 4;
   localparam int LP_BIT_CHG_MIRROR = 3;
   localparam int LP_BIT_DCHG_MIRROR = 2;
   localparam int LP_BIT_CHARGE_ALLOW = 1;
   localparam int LP_BIT_DISCHARGE_ALLOW = 0;
   localparam int LP_BIT_BOOT_HI = 5;
   localparam int LP_BIT_OPSEL = 4;
   localparam int LP_BIT_BOOT_LO = 3;
   localparam int LP_BIT_COPY = 7;
   localparam int LP_BIT_FREEZE = 6;
   localparam int LP_BIT_BLK1 = 1;
   localparam int LP_BIT_BLK0 = 0;
   localparam int LP_BIT_PIN_LATCH = 7;
   localparam int LP_BIT_HEAT = 0;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic LP_HIGH_CELL_RST = 1'b0;
   localparam logic LP_LOW_CELL_RST = 1'b1;
   localparam logic LP_EXCESS_RST = 1'b1;
   localparam logic LP_ALLOW_RST = 1'b1;
   localparam logic LP_FREEZE_RST = 1'b0;
   localparam logic LP_PIN_LATCH_RST = 1'b1;
   localparam logic LP_HEAT_RST = 1'b0;
   localparam logic [7:0] LP_NVM_FACTORY = 8'h00;
   localparam logic [7:0] LP_READ_IDLE = 8'hff;

   // ***************************************************
   // opcodes, identity, crc, timing
   // ***************************************************
   localparam logic [7:0] LP_OP_ID_A = 8'h33;
   localparam logic [7:0] LP_OP_ID_B = 8'h39;
   localparam logic [7:0] LP_CRC_POLY = 8'h8c;
   localparam int LP_CLK_PERIOD_NS = 5;
   localparam int LP_COPY_TIME_US = 10;
   localparam int LP_COPY_CYCLES = (LP_COPY_TIME_US * 1000) / LP_CLK_PERIOD_NS;

   // ***************************************************
   // host register map (axi4-lite byte addresses)
   // ***************************************************
   localparam logic [7:0] LP_AXI_CTRL = 8'h00;
   localparam logic [7:0] LP_AXI_ADDR = 8'h04;
   localparam logic [7:0] LP_AXI_WDATA = 8'h08;
   localparam logic [7:0] LP_AXI_RDATA = 8'h0c;
   localparam logic [7:0] LP_AXI_STATUS = 8'h10;
   localparam logic [7:0] LP_AXI_ID_LO = 8'h14;
   localparam logic [7:0] LP_AXI_ID_HI = 8'h18;
   localparam int LP_ST_BUSY = 0;
   localparam int LP_ST_ID_OK = 1;
   localparam int LP_ST_ID_DONE = 2;
   localparam logic [1:0] LP_RESP_OKAY = 2'b00;
   localparam logic [1:0] LP_RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      LP_CMD_READ = 3'h0,
      LP_CMD_WRITE = 3'h1,
      LP_CMD_COPY = 3'h2,
      LP_CMD_RECALL = 3'h3,
      LP_CMD_LOCK = 3'h4,
      LP_CMD_ID_READ = 3'h5,
      LP_CMD_ID_CHECK = 3'h6
   } lp_cmd_t;

endpackage

/* logic/lp_link_if.sv */
// Purpose: link between host end and protector end
// Assumes: one request per cycle at most, every request answered next cycle
// Notes: single-wire bit signalling is abstracted to byte transfers
interface lp_link_if;
   import lp_pkg::*;
   logic req_valid;
   lp_cmd_t req_cmd;
   logic [7:0] req_addr;
   logic [7:0] req_data;
   logic rsp_valid;
   logic [7:0] rsp_data;

   modport host (output req_valid, output req_cmd, output req_addr, output req_data,
                 input rsp_valid, input rsp_data);
   modport device (input req_valid, input req_cmd, input req_addr, input req_data,
                   output rsp_valid, output rsp_data);
endinterface

/* logic/lp_host.sv */
// Purpose: host end: takes orders over axi4-lite and drives the protector link
// Assumes: one outstanding axi write and one read
// Notes: id check reads all eight identity bytes and runs the crc
module lp_host
   import lp_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link
   lp_link_if.host link
);
   import lp_pkg::*;

   typedef enum logic [1:0] {
      LP_H_IDLE = 2'b01,
      LP_H_WAIT = 2'b10
   } lp_hstate_t;

   lp_hstate_t state;
   logic aw_got, w_got, do_write, start;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   lp_cmd_t cmd_reg;
   logic [7:0] addr_reg, wdata_reg, rdata_reg, crc;
   logic [63:0] id_bytes;
   logic id_ok, id_done;
   logic [2:0] idx;

   function automatic logic [7:0] lp_crc_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ LP_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ***************************************************
   // axi4-lite slave
   // ***************************************************
   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_got && w_got && !s_axi_bvalid;
   assign start = do_write && aw_addr == LP_AXI_CTRL && w_strb[0] && state == LP_H_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= LP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == LP_AXI_CTRL || aw_addr == LP_AXI_ADDR
                            || aw_addr == LP_AXI_WDATA) ? LP_RESP_OKAY : LP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= LP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= LP_RESP_OKAY;
         unique case (s_axi_araddr)
            LP_AXI_CTRL: s_axi_rdata <= {29'h0, cmd_reg};
            LP_AXI_ADDR: s_axi_rdata <= {24'h0, addr_reg};
            LP_AXI_WDATA: s_axi_rdata <= {24'h0, wdata_reg};
            LP_AXI_RDATA: s_axi_rdata <= {24'h0, rdata_reg};
            LP_AXI_STATUS: s_axi_rdata <= {29'h0, id_done, id_ok, state == LP_H_WAIT};
            LP_AXI_ID_LO: s_axi_rdata <= id_bytes[31:0];
            LP_AXI_ID_HI: s_axi_rdata <= id_bytes[63:32];
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= LP_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***************************************************
   // order registers
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_reg <= LP_CMD_READ;
         addr_reg <= '0;
         wdata_reg <= '0;
      end else if (do_write && w_strb[0]) begin
         if (start) begin
            cmd_reg <= lp_cmd_t'(w_data[2:0]);
         end
         if (aw_addr == LP_AXI_ADDR) begin
            addr_reg <= w_data[7:0];
         end
         if (aw_addr == LP_AXI_WDATA) begin
            wdata_reg <= w_data[7:0];
         end
      end
   end

   // ***************************************************
   // link sequencer and identity check
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= LP_H_IDLE;
         link.req_valid <= 1'b0;
         link.req_cmd <= LP_CMD_READ;
         link.req_addr <= '0;
         link.req_data <= '0;
         rdata_reg <= '0;
         id_bytes <= '0;
         crc <= '0;
         idx <= '0;
         id_ok <= 1'b0;
         id_done <= 1'b0;
      end else begin
         link.req_valid <= 1'b0;
         unique case (state)
            LP_H_IDLE: begin
               if (start) begin
                  state <= LP_H_WAIT;
                  link.req_valid <= 1'b1;
                  idx <= '0;
                  crc <= '0;
                  if (lp_cmd_t'(w_data[2:0]) == LP_CMD_ID_CHECK) begin
                     link.req_cmd <= LP_CMD_ID_READ;
                     link.req_addr <= '0;
                     id_done <= 1'b0;
                     id_ok <= 1'b0;
                  end else begin
                     link.req_cmd <= lp_cmd_t'(w_data[2:0]);
                     link.req_addr <= addr_reg;
                  end
                  link.req_data <= wdata_reg;
               end
            end
            LP_H_WAIT: begin
               if (link.rsp_valid) begin
                  rdata_reg <= link.rsp_data;
                  if (cmd_reg == LP_CMD_ID_CHECK) begin
                     id_bytes[{idx, 3'b000} +: 8] <= link.rsp_data;
                     if (idx == 3'h7) begin
                        id_ok <= (crc == link.rsp_data);
                        id_done <= 1'b1;
                        state <= LP_H_IDLE;
                     end else begin
                        crc <= lp_crc_byte(crc, link.rsp_data);
                        idx <= idx + 3'h1;
                        link.req_valid <= 1'b1;
                        link.req_addr <= {5'h00, idx + 3'h1};
                     end
                  end else begin
                     state <= LP_H_IDLE;
                  end
               end
            end
         endcase
      end
   end

endmodule // lp_host

/* sim/lp_chk.sv */
// Purpose: link checker for the protector pair
// Assumes: all link signals on aclk
// Notes: watches answers only
module lp_chk
   import lp_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link
   input wire logic req_valid,
   input wire lp_cmd_t req_cmd,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd;
   assign rd = req_valid && req_cmd == LP_CMD_READ;
   property p_answer; req_valid |=> rsp_valid; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_bad_op;
      req_valid && req_cmd == LP_CMD_ID_READ && req_data != LP_OP_ID_A
         && req_data != LP_OP_ID_B |-> ##1 rsp_data == LP_READ_IDLE;
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("bad opcode answered");
   property p_ack;
      req_valid && req_cmd inside {LP_CMD_WRITE, LP_CMD_COPY, LP_CMD_LOCK} |=> rsp_data == 8'h00;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not zero");
   property p_resv; rd && req_addr inside {[8'h02:8'h06]} |=> rsp_data == 8'h00; endproperty
   a_resv: assert property (p_resv) else $error("reserved read");
   property p_boot; rd && req_addr == LP_REG_BOOT |=> (rsp_data & 8'hc7) == 8'h00; endproperty
   a_boot: assert property (p_boot) else $error("boot byte");
   property p_nvm; rd && req_addr == LP_REG_NVM |=> rsp_data[5:2] == 4'h0; endproperty
   a_nvm: assert property (p_nvm) else $error("nvm byte");
   property p_sw; rd && req_addr == LP_REG_SWITCH |=> rsp_data[6:1] == 6'h00; endproperty
   a_sw: assert property (p_sw) else $error("switch byte");
   property p_guard; rd && req_addr == LP_REG_GUARD |=> !rsp_data[5]; endproperty
   a_guard: assert property (p_guard) else $error("guard bit 5");
endmodule // lp_chk

/* sim/lp_tb.sv */
// Purpose: bench for host and protector ends
// Assumes: axi4-lite orders drive the link
// Notes: copy count shortened
module lp_tb import lp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic awready, wready, bvalid, arready, rvalid, cg, dg, act;
   logic [1:0] bresp, rresp, r;
   // from bit 0: over volt, under volt, over current, over temp, pin_n, charger
   logic [5:0] cond = 6'h10;
   int bad_count = 0, samples_checked = 0, cyc = 0;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
   lp_link_if link();
   lp_host u_lp_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
   lp_device #(.FAMILY_CODE(8'h6b), .ID_CRC(8'ha9), .COPY_CYCLES(200)) u_lp_device(.aclk(aclk),
      .aresetn(aresetn), .link(link), .cell_over_voltage(cond[0]),
      .cell_under_voltage(cond[1]), .pack_over_current(cond[2]), .die_over_temp(cond[3]),
      .charger_present(cond[5]), .power_switch_pin_n(cond[4]), .charge_gate(cg),
      .discharge_gate(dg), .active_mode(act));
   lp_chk u_lp_chk(.aclk(aclk), .aresetn(aresetn), .req_valid(link.req_valid),
      .req_cmd(link.req_cmd), .req_addr(link.req_addr), .req_data(link.req_data),
      .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      v = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   task automatic op(input lp_cmd_t c, input logic [7:0] a, input logic [7:0] d);
      wr(LP_AXI_ADDR, {24'h0, a});
      wr(LP_AXI_WDATA, {24'h0, d});
      wr(LP_AXI_CTRL, {29'h0, c});
      do rd(LP_AXI_STATUS); while (v[LP_ST_BUSY] !== 1'h0);
      rd(LP_AXI_RDATA);
   endtask
   task pulse(input int i, input logic lvl);
      cond[i] <= lvl;
      repeat (4) @(posedge aclk);
      cond[i] <= ~lvl;
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      op(LP_CMD_READ, LP_REG_GUARD, 8'h00);
      `CHK(v[7:0], 8'h5f)
      op(LP_CMD_READ, LP_REG_SWITCH, 8'h00);
      `CHK(v[7:0], 8'h80)
      op(LP_CMD_READ, LP_REG_BOOT, 8'h00);
      `CHK(v[7:0], 8'h00)
      op(LP_CMD_READ, 8'h02, 8'h00);
      `CHK(v[7:0], 8'h00)
      op(LP_CMD_WRITE, LP_REG_GUARD, 8'h02);
      op(LP_CMD_READ, LP_REG_GUARD, 8'h00);
      `CHK({v[7:0], dg, cg}, {8'h0a, 2'h1})
      pulse(0, 1'h1);
      pulse(2, 1'h1);
      op(LP_CMD_READ, LP_REG_GUARD, 8'h00);
      `CHK(v[7:0], 8'h9a)
      op(LP_CMD_WRITE, LP_REG_GUARD, 8'h01);
      op(LP_CMD_READ, LP_REG_GUARD, 8'h00);
      `CHK({v[7:0], cg}, {8'h05, 1'h0})
      pulse(1, 1'h1);
      `CHK(act, 1'h0)
      pulse(4, 1'h0);
      `CHK(act, 1'h1)
      op(LP_CMD_READ, LP_REG_GUARD, 8'h00);
      `CHK(v[7:0], 8'h4f)
      pulse(3, 1'h1);
      op(LP_CMD_READ, LP_REG_SWITCH, 8'h00);
      `CHK({v[7:0], dg}, {8'h01, 1'h0})
      op(LP_CMD_WRITE, LP_REG_SWITCH, 8'h80);
      op(LP_CMD_READ, LP_REG_SWITCH, 8'h00);
      `CHK({v[7:0], dg}, {8'h80, 1'h1})
      op(LP_CMD_WRITE, 8'h20, 8'ha5);
      op(LP_CMD_WRITE, LP_REG_NVM, 8'h40);
      op(LP_CMD_LOCK, 8'h20, 8'h00);
      op(LP_CMD_READ, LP_REG_NVM, 8'h00);
      `CHK(v[7:0], 8'h01)
      op(LP_CMD_WRITE, 8'h20, 8'h3c);
      op(LP_CMD_READ, 8'h20, 8'h00);
      `CHK(v[7:0], 8'ha5)
      op(LP_CMD_ID_READ, 8'h00, LP_OP_ID_A);
      `CHK(v[7:0], 8'h6b)
      op(LP_CMD_ID_READ, 8'h00, LP_OP_ID_B);
      `CHK(v[7:0], 8'hff)
      op(LP_CMD_ID_READ, 8'h00, 8'h55);
      `CHK(v[7:0], 8'hff)
      op(LP_CMD_WRITE, 8'h31, 8'h10);
      op(LP_CMD_COPY, 8'h30, 8'h00);
      op(LP_CMD_READ, LP_REG_NVM, 8'h00);
      `CHK(v[7:0], 8'h81)
      op(LP_CMD_WRITE, 8'h31, 8'h00);
      repeat (200) @(posedge aclk);
      op(LP_CMD_RECALL, 8'h30, 8'h00);
      op(LP_CMD_READ, LP_REG_BOOT, 8'h00);
      `CHK(v[7:0], 8'h10)
      op(LP_CMD_ID_CHECK, 8'h00, LP_OP_ID_B);
      `CHK(v[7:0], 8'ha9)
      rd(LP_AXI_STATUS);
      `CHK(v, 32'h6)
      rd(LP_AXI_ID_LO);
      `CHK(v, 32'h0000016b)
      wr(8'h1c, 32'h0);
      `CHK(r, LP_RESP_SLVERR)
      rd(8'h1c);
      `CHK(r, LP_RESP_SLVERR)
      summarize();
   end
endmodule // lp_tb
